// File: logic/cmm_consts.svh
// Offsets, field positions, reset values and limits of the core register bank
`ifndef CMM_CONSTS_SVH
`define CMM_CONSTS_SVH
`define CMM_SP_ADDR 8'h81
`define CMM_DP0L_ADDR 8'h82
`define CMM_DP0H_ADDR 8'h83
`define CMM_DP1L_ADDR 8'h84
`define CMM_DP1H_ADDR 8'h85
`define CMM_XPAGE_ADDR 8'h86
`define CMM_TIMING_ADDR 8'h8e
`define CMM_IFACE_ADDR 8'h8f
`define CMM_AUX_ADDR 8'h91
`define CMM_IND_IDX_ADDR 8'hbc
`define CMM_IND_VAL_ADDR 8'hbd
`define CMM_SFR_WINDOW_SELECT_ADDR 8'hbe
`define CMM_FLAGS_ADDR 8'hd0
`define CMM_ACC_ADDR 8'he0
`define CMM_B_ADDR 8'hf0
`define CMM_SP_RST 8'h07
`define CMM_TIMING_RST 8'h10
`define CMM_ZERO_RST 8'h00
`define CMM_TIMING_WMASK 8'h73
`define CMM_IFACE_WMASK 8'h01
`define CMM_AUX_WMASK 8'hd1
`define CMM_SFR_WINDOW_SELECT_WMASK 8'h03
`define CMM_FLAGS_WMASK 8'hfe
`define CMM_CY_BIT 7
`define CMM_AC_BIT 6
`define CMM_OV_BIT 2
`define CMM_P_BIT 0
`define CMM_RS_HI 4
`define CMM_RS_LO 3
`define CMM_ITS_HI 6
`define CMM_ITS_LO 4
`define CMM_CLKOUT_HI 1
`define CMM_CLKOUT_LO 0
`define CMM_LOCK_BIT 6
`define CMM_BOOT_SERVICE_ENABLE_BIT 0
`define CMM_DPS_BIT 0
`define CMM_PGMODE_BIT 0
`define CMM_PGNUM_BIT 1
`define CMM_FLASH_TOP 16'h3fff
`define CMM_FLASH_SIZE 16'h4000
`define CMM_BOOT_BLK_SHIFT 7
`define CMM_BOOT_NMAX 4'h8
`define CMM_XRAM_TOP 16'h03ff
`endif

// File: logic/cmm_core_regs.sv
// Core memory map decode and core special function registers
//
// Notes on behaviour
// - Flash is 0000 to 3FFF; top N blocks of 128 bytes, N 0..8, are boot.
// - N zero means no boot area; each step grows it down by 128 bytes.
// - N is a strap captured once after reset; code cannot change it.
// - Bytes 00h-7Fh reach RAM both directly and indirectly.
// - Bytes 80h-FFh reach RAM only indirectly; direct access selects SFRs.
// - Expanded 1K RAM sits at 0000h-03FFh while the disable bit is zero.
// - Index-register external moves take the upper byte from the page register.
// - Bank select maps R0-R7 into 00h-1Fh, eight bytes per bank.
// - Parity bit tracks the accumulator so together they hold even ones.
// - Stack pointer resets to 07h and increments before each push.
// - Each pointer loads whole by 16-bit load or bytewise through SFRs.
// - Aux bit 0 chooses the pointer; pointer operations use only it.
// - Timing field gives machine cycle of field plus one clocks, reset 001.
// - Clock pin field selects I/O, Fosc, Fosc/2, Fosc/4 under the RC oscillator.
// - Interface bit 0 enables the boot service, reset zero.
// - Interface bit 6 reports code lock and ignores writes.
// - B register is the second operand for multiply and divide, else scratch.
// - Page selector bit 0 picks indirect (0) or paged (1) SFR access.
// - Page selector bit 1 picks the page only in paged mode.
// - Indirect mode writes index then value; value goes to that peripheral register.
`timescale 1ns/100ps
`default_nettype none
`include "cmm_consts.svh"
module cmm_core_regs
    import cmm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire cmm_sfr_req_t sfr_req_i,
    output logic [7:0] sfr_rdata_o,
    output logic sfr_hit_o,
    input wire logic acc_wr_i,
    input wire logic [7:0] acc_wdata_i,
    input wire logic b_wr_i,
    input wire logic [7:0] b_wdata_i,
    input wire logic flags_wr_i,
    input wire cmm_alu_flags_t flags_i,
    input wire logic stack_push_i,
    input wire logic stack_pop_i,
    input wire logic data_pointer_load_i,
    input wire logic [15:0] data_pointer_load_val_i,
    input wire logic data_pointer_inc_i,
    input wire logic [2:0] work_reg_i,
    input wire cmm_data_ref_t data_ref_i,
    input wire logic xmove_via_index_i,
    input wire logic [7:0] xmove_index_i,
    input wire logic xram_disable_i,
    input wire logic [15:0] code_addr_i,
    input wire logic [3:0] boot_blocks_i,
    input wire logic code_lock_i,
    input wire logic rc_osc_sel_i,
    output logic [7:0] acc_o,
    output logic [7:0] b_o,
    output logic [7:0] flags_o,
    output logic [7:0] sp_o,
    output logic [15:0] data_pointer_o,
    output logic pointer_choice_o,
    output logic [7:0] work_reg_addr_o,
    output logic iram_sel_o,
    output logic sfr_sel_o,
    output logic [15:0] xmove_addr_o,
    output logic xram_hit_o,
    output logic boot_area_o,
    output logic [3:0] boot_blocks_o,
    output logic [3:0] cycle_clocks_o,
    output logic cycle_strobe_o,
    output logic [1:0] clock_pin_output_sel_o,
    output logic boot_service_enable_o,
    output logic code_lock_status_o,
    output logic sfr_page_mode_o,
    output logic sfr_page_o,
    output logic ind_wr_o,
    output logic [7:0] indirect_sfr_index_o,
    output logic [7:0] indirect_sfr_value_o
);

    function automatic logic [7:0] cmm_bank_addr(input logic [1:0] bank, input logic [2:0] rn);
        cmm_bank_addr = {3'h0, bank, rn};
    endfunction

    function automatic logic [15:0] cmm_boot_base(input logic [3:0] n);
        cmm_boot_base = `CMM_FLASH_SIZE - ({12'h000, n} << `CMM_BOOT_BLK_SHIFT);
    endfunction

    logic [7:0] acc_reg, acc_next;
    logic [7:0] b_reg, b_next;
    logic [7:0] flags_reg, flags_next;
    logic [7:0] sp_reg, sp_next;
    logic [7:0] dp0l_reg, dp0h_reg, dp1l_reg, dp1h_reg;
    logic [15:0] dp0_next, dp1_next, dp_cur;
    logic [7:0] xpage_reg, xpage_next;
    logic [7:0] timing_reg, timing_next;
    logic [7:0] iface_reg, iface_next;
    logic [7:0] aux_reg, aux_next;
    logic [7:0] sfr_window_select_reg, sfr_window_select_next;
    logic [7:0] ind_idx_reg;
    logic [7:0] ind_val_reg;
    logic ind_wr_reg;
    logic [7:0] rdata_reg;
    logic hit_reg;
    logic [3:0] boot_n_reg;
    logic strap_done_reg;
    logic lock_reg;
    logic [2:0] cyc_cnt_reg;
    logic strobe_reg;
    logic [15:0] data_pointer_out_reg;
    logic [7:0] bank_addr_reg;
    logic iram_reg, sfrsel_reg;
    logic [15:0] xaddr_reg;
    logic xhit_reg;
    logic boot_reg;

    // Write strobes
    wire logic wr = sfr_req_i.wr;
    wire logic [7:0] wd = sfr_req_i.wdata;
    wire logic wr_sp = wr && sfr_req_i.addr == `CMM_SP_ADDR;
    wire logic wr_dp0l = wr && sfr_req_i.addr == `CMM_DP0L_ADDR;
    wire logic wr_dp0h = wr && sfr_req_i.addr == `CMM_DP0H_ADDR;
    wire logic wr_dp1l = wr && sfr_req_i.addr == `CMM_DP1L_ADDR;
    wire logic wr_dp1h = wr && sfr_req_i.addr == `CMM_DP1H_ADDR;
    wire logic wr_xpage = wr && sfr_req_i.addr == `CMM_XPAGE_ADDR;
    wire logic wr_timing = wr && sfr_req_i.addr == `CMM_TIMING_ADDR;
    wire logic wr_iface = wr && sfr_req_i.addr == `CMM_IFACE_ADDR;
    wire logic wr_aux = wr && sfr_req_i.addr == `CMM_AUX_ADDR;
    wire logic wr_sfr_window_select = wr && sfr_req_i.addr == `CMM_SFR_WINDOW_SELECT_ADDR;
    wire logic wr_flags = wr && sfr_req_i.addr == `CMM_FLAGS_ADDR;
    wire logic wr_acc = wr && sfr_req_i.addr == `CMM_ACC_ADDR;
    wire logic wr_b = wr && sfr_req_i.addr == `CMM_B_ADDR;
    wire logic indirect_mode = !sfr_window_select_reg[`CMM_PGMODE_BIT];
    wire logic wr_idx = wr && indirect_mode && sfr_req_i.addr == `CMM_IND_IDX_ADDR;
    wire logic wr_val = wr && indirect_mode && sfr_req_i.addr == `CMM_IND_VAL_ADDR;
    wire logic sel_dp1 = aux_reg[`CMM_DPS_BIT];
    wire logic sel_dp1_next = aux_next[`CMM_DPS_BIT];

    // Core writes win over SFR writes in the same cycle
    assign acc_next = acc_wr_i ? acc_wdata_i : (wr_acc ? wd : acc_reg);
    assign b_next = b_wr_i ? b_wdata_i : (wr_b ? wd : b_reg);
    wire logic [7:0] flags_sfr = wr_flags ? (wd & `CMM_FLAGS_WMASK) : flags_reg;
    wire logic [7:0] flags_alu = {flags_i.carry, flags_i.half_carry, flags_sfr[5:3], flags_i.ovf, flags_sfr[1:0]};
    wire logic [7:0] flags_mix = flags_wr_i ? flags_alu : flags_sfr;
    assign flags_next = {flags_mix[7:1], ^acc_next};
    assign sp_next = stack_push_i ? sp_reg + 8'h01 :
                     stack_pop_i ? sp_reg - 8'h01 :
                     wr_sp ? wd : sp_reg;
    assign dp_cur = sel_dp1 ? {dp1h_reg, dp1l_reg} : {dp0h_reg, dp0l_reg};
    wire logic [15:0] dp_core = data_pointer_load_i ? data_pointer_load_val_i : dp_cur + 16'h0001;
    wire logic dp_core_wr = data_pointer_load_i || data_pointer_inc_i;
    assign dp0_next = (dp_core_wr && !sel_dp1) ? dp_core :
                      {wr_dp0h ? wd : dp0h_reg, wr_dp0l ? wd : dp0l_reg};
    assign dp1_next = (dp_core_wr && sel_dp1) ? dp_core :
                      {wr_dp1h ? wd : dp1h_reg, wr_dp1l ? wd : dp1l_reg};
    assign xpage_next = wr_xpage ? wd : xpage_reg;
    assign timing_next = wr_timing ? (wd & `CMM_TIMING_WMASK) : timing_reg;
    assign iface_next = wr_iface ? (wd & `CMM_IFACE_WMASK) : iface_reg;
    assign aux_next = wr_aux ? (wd & `CMM_AUX_WMASK) : aux_reg;
    assign sfr_window_select_next = wr_sfr_window_select ? (wd & `CMM_SFR_WINDOW_SELECT_WMASK) : sfr_window_select_reg;

    // Read mux; code lock status is merged on read only
    wire logic [7:0] iface_view = iface_reg | ({7'h00, lock_reg} << `CMM_LOCK_BIT);
    logic [7:0] rd_mux;
    logic rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        case (sfr_req_i.addr)
            `CMM_SP_ADDR: rd_mux = sp_reg;
            `CMM_DP0L_ADDR: rd_mux = dp0l_reg;
            `CMM_DP0H_ADDR: rd_mux = dp0h_reg;
            `CMM_DP1L_ADDR: rd_mux = dp1l_reg;
            `CMM_DP1H_ADDR: rd_mux = dp1h_reg;
            `CMM_XPAGE_ADDR: rd_mux = xpage_reg;
            `CMM_TIMING_ADDR: rd_mux = timing_reg;
            `CMM_IFACE_ADDR: rd_mux = iface_view;
            `CMM_AUX_ADDR: rd_mux = aux_reg;
            `CMM_IND_IDX_ADDR: rd_mux = ind_idx_reg;
            `CMM_IND_VAL_ADDR: rd_mux = ind_val_reg;
            `CMM_SFR_WINDOW_SELECT_ADDR: rd_mux = sfr_window_select_reg;
            `CMM_FLAGS_ADDR: rd_mux = flags_reg;
            `CMM_ACC_ADDR: rd_mux = acc_reg;
            `CMM_B_ADDR: rd_mux = b_reg;
            default: begin
                rd_mux = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Memory map decode
    wire logic [15:0] xaddr = xmove_via_index_i ? {xpage_reg, xmove_index_i} : dp_cur;
    wire logic xhit = !xram_disable_i && xaddr <= `CMM_XRAM_TOP;
    wire logic to_sfr = !data_ref_i.indirect && data_ref_i.addr[7];
    wire logic in_boot = boot_n_reg != 4'h0 && code_addr_i >= cmm_boot_base(boot_n_reg)
                         && code_addr_i <= `CMM_FLASH_TOP;
    wire logic [3:0] strap_n = boot_blocks_i > `CMM_BOOT_NMAX ? `CMM_BOOT_NMAX : boot_blocks_i;
    wire logic [2:0] its = timing_reg[`CMM_ITS_HI:`CMM_ITS_LO];
    wire logic [2:0] its_next = timing_next[`CMM_ITS_HI:`CMM_ITS_LO];
    wire logic cyc_wrap = cyc_cnt_reg >= its;
    wire logic [1:0] clk_sel_next = rc_osc_sel_i ? timing_next[`CMM_CLKOUT_HI:`CMM_CLKOUT_LO] : 2'h0;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            acc_reg <= `CMM_ZERO_RST;
            b_reg <= `CMM_ZERO_RST;
            flags_reg <= `CMM_ZERO_RST;
            sp_reg <= `CMM_SP_RST;
            {dp0h_reg, dp0l_reg, dp1h_reg, dp1l_reg} <= 32'h0000_0000;
            xpage_reg <= `CMM_ZERO_RST;
            timing_reg <= `CMM_TIMING_RST;
            iface_reg <= `CMM_ZERO_RST;
            aux_reg <= `CMM_ZERO_RST;
            sfr_window_select_reg <= `CMM_ZERO_RST;
        end else begin
            acc_reg <= acc_next;
            b_reg <= b_next;
            flags_reg <= flags_next;
            sp_reg <= sp_next;
            {dp0h_reg, dp0l_reg} <= dp0_next;
            {dp1h_reg, dp1l_reg} <= dp1_next;
            xpage_reg <= xpage_next;
            timing_reg <= timing_next;
            iface_reg <= iface_next;
            aux_reg <= aux_next;
            sfr_window_select_reg <= sfr_window_select_next;
        end
    end

    // Indirect peripheral access
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ind_idx_reg <= `CMM_ZERO_RST;
            ind_val_reg <= `CMM_ZERO_RST;
            ind_wr_reg <= 1'b0;
        end else begin
            if (wr_idx) begin
                ind_idx_reg <= wd;
            end
            if (wr_val) begin
                ind_val_reg <= wd;
            end
            ind_wr_reg <= wr_val;
        end
    end

    // Strap capture, lock status, cycle timer
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            boot_n_reg <= 4'h0;
            strap_done_reg <= 1'b0;
            lock_reg <= 1'b0;
            cyc_cnt_reg <= 3'h0;
            strobe_reg <= 1'b0;
        end else begin
            if (!strap_done_reg) begin
                boot_n_reg <= strap_n;
            end
            strap_done_reg <= 1'b1;
            lock_reg <= code_lock_i;
            cyc_cnt_reg <= cyc_wrap ? 3'h0 : cyc_cnt_reg + 3'h1;
            strobe_reg <= cyc_wrap;
        end
    end

    // Registered outputs
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rdata_reg <= 8'h00;
            hit_reg <= 1'b0;
            data_pointer_out_reg <= 16'h0000;
            bank_addr_reg <= 8'h00;
            iram_reg <= 1'b0;
            sfrsel_reg <= 1'b0;
            xaddr_reg <= 16'h0000;
            xhit_reg <= 1'b0;
            boot_reg <= 1'b0;
        end else begin
            rdata_reg <= sfr_req_i.rd ? rd_mux : 8'h00;
            hit_reg <= (sfr_req_i.rd || wr) && rd_hit;
            data_pointer_out_reg <= sel_dp1_next ? dp1_next : dp0_next;
            bank_addr_reg <= cmm_bank_addr(flags_reg[`CMM_RS_HI:`CMM_RS_LO], work_reg_i);
            iram_reg <= !to_sfr;
            sfrsel_reg <= to_sfr;
            xaddr_reg <= xaddr;
            xhit_reg <= xhit;
            boot_reg <= in_boot;
        end
    end

    logic [3:0] clocks_reg;
    logic [1:0] clksel_reg;
    logic [1:0] page_reg;
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            clocks_reg <= 4'h2;
            clksel_reg <= 2'h0;
            page_reg <= 2'h0;
        end else begin
            clocks_reg <= {1'b0, its_next} + 4'h1;
            clksel_reg <= clk_sel_next;
            page_reg <= {sfr_window_select_next[`CMM_PGMODE_BIT] & sfr_window_select_next[`CMM_PGNUM_BIT],
                         sfr_window_select_next[`CMM_PGMODE_BIT]};
        end
    end

    assign sfr_rdata_o = rdata_reg;
    assign sfr_hit_o = hit_reg;
    assign acc_o = acc_reg;
    assign b_o = b_reg;
    assign flags_o = flags_reg;
    assign sp_o = sp_reg;
    assign data_pointer_o = data_pointer_out_reg;
    assign pointer_choice_o = sel_dp1;
    assign work_reg_addr_o = bank_addr_reg;
    assign iram_sel_o = iram_reg;
    assign sfr_sel_o = sfrsel_reg;
    assign xmove_addr_o = xaddr_reg;
    assign xram_hit_o = xhit_reg;
    assign boot_area_o = boot_reg;
    assign boot_blocks_o = boot_n_reg;
    assign cycle_clocks_o = clocks_reg;
    assign cycle_strobe_o = strobe_reg;
    assign clock_pin_output_sel_o = clksel_reg;
    assign boot_service_enable_o = iface_reg[`CMM_BOOT_SERVICE_ENABLE_BIT];
    assign code_lock_status_o = lock_reg;
    assign sfr_page_mode_o = page_reg[0];
    assign sfr_page_o = page_reg[1];
    assign ind_wr_o = ind_wr_reg;
    assign indirect_sfr_index_o = ind_idx_reg;
    assign indirect_sfr_value_o = ind_val_reg;

    chk_parity_even: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ^{acc_o, flags_o[`CMM_P_BIT]} == 1'b0) else $error("parity bit not even with accumulator");
    chk_sp_preinc: assert property (@(posedge clk_i) disable iff (!rstn_i)
        stack_push_i |=> sp_o == $past(sp_o) + 8'h01) else $error("push did not pre-increment stack");
    chk_sp_reset: assert property (@(posedge clk_i)
        !rstn_i |=> sp_o == 8'h07 && cycle_clocks_o == 4'h2) else $error("stack or timing reset value wrong");
    chk_bank_map: assert property (@(posedge clk_i) disable iff (!rstn_i)
        work_reg_addr_o[7:5] == 3'h0 && work_reg_addr_o[2:0] == $past(work_reg_i)
        && work_reg_addr_o[4:3] == $past(flags_o[4:3])) else $error("bank map wrong");
    chk_upper_direct: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (!data_ref_i.indirect && data_ref_i.addr[7]) |=> sfr_sel_o && !iram_sel_o)
        else $error("direct upper address reached RAM");
    chk_xram_page: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (xmove_via_index_i && !xram_disable_i) |=> xmove_addr_o[15:8] == $past(xpage_reg)
        && xram_hit_o == (xmove_addr_o <= 16'h03ff)) else $error("paged external address wrong");
    chk_lock_ro: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_iface |=> iface_reg[7:1] == 7'h00) else $error("read-only interface bit written");
    chk_ind_fwd: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_val |=> ind_wr_o && indirect_sfr_value_o == $past(wd) ##1 !ind_wr_o || $past(wr_val))
        else $error("indirect value not forwarded");
    chk_page_ignored: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !sfr_page_mode_o |-> !sfr_page_o) else $error("page bit honoured in indirect mode");
    chk_strap_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
        strap_done_reg && $past(strap_done_reg) |-> $stable(boot_blocks_o))
        else $error("boot partition changed while running");
    chk_cycle_len: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $stable(timing_reg) && !wr_timing && cycle_strobe_o && its == 3'h1
        |-> ##1 !cycle_strobe_o ##1 cycle_strobe_o)
        else $error("machine cycle length wrong");
    chk_boot_low: assert property (@(posedge clk_i) disable iff (!rstn_i)
        code_addr_i < 16'h3c00 |=> !boot_area_o) else $error("boot area below eight blocks");
    chk_data_pointer_load: assert property (@(posedge clk_i) disable iff (!rstn_i)
        data_pointer_load_i && !wr_aux |=> data_pointer_o == $past(data_pointer_load_val_i)) else $error("pointer load lost");
    chk_ind_refused: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr && !indirect_mode && sfr_req_i.addr == `CMM_IND_VAL_ADDR |=> !ind_wr_o && $stable(indirect_sfr_value_o))
        else $error("indirect write taken in paged mode");
    chk_clkpin_gpio: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !rc_osc_sel_i |=> clock_pin_output_sel_o == 2'h0) else $error("clock pin driven off RC oscillator");
endmodule
`default_nettype wire

// File: logic/cmm_pkg.sv
// Types shared by the core register bank
package cmm_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } cmm_sfr_req_t;
    typedef struct packed {
        logic carry;
        logic half_carry;
        logic ovf;
    } cmm_alu_flags_t;
    typedef struct packed {
        logic [7:0] addr;
        logic indirect;
    } cmm_data_ref_t;
endpackage

// File: verif/cmm_core_regs_tb_top.sv
// Self-checking testbench for the core register bank
`timescale 1ns/100ps
`default_nettype none
`include "cmm_consts.svh"
module cmm_core_regs_tb_top
    import cmm_pkg::*;
;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    cmm_sfr_req_t sfr_req_i = '0;
    cmm_alu_flags_t flags_i = '0;
    cmm_data_ref_t data_ref_i = '0;
    logic acc_wr_i = 1'b0, b_wr_i = 1'b0, flags_wr_i = 1'b0, stack_push_i = 1'b0, stack_pop_i = 1'b0;
    logic data_pointer_load_i = 1'b0, data_pointer_inc_i = 1'b0, xmove_via_index_i = 1'b0, xram_disable_i = 1'b0;
    logic code_lock_i = 1'b0, rc_osc_sel_i = 1'b0;
    logic [7:0] acc_wdata_i = '0, b_wdata_i = '0, xmove_index_i = '0;
    logic [15:0] data_pointer_load_val_i = '0, code_addr_i = '0;
    logic [2:0] work_reg_i = '0;
    logic [3:0] boot_blocks_i = 4'h2;
    logic [7:0] sfr_rdata_o, acc_o, b_o, flags_o, sp_o, work_reg_addr_o, indirect_sfr_index_o, indirect_sfr_value_o;
    logic [15:0] data_pointer_o, xmove_addr_o;
    logic [3:0] boot_blocks_o, cycle_clocks_o;
    logic [1:0] clock_pin_output_sel_o;
    logic sfr_hit_o, pointer_choice_o, iram_sel_o, sfr_sel_o, xram_hit_o, boot_area_o, cycle_strobe_o;
    logic boot_service_enable_o, code_lock_status_o, sfr_page_mode_o, sfr_page_o, ind_wr_o;
    int err_count = 0;
    int n_checks = 0;

    cmm_core_regs cmm_core_regs_inst (.clk_i(clk_i), .rstn_i(rstn_i), .sfr_req_i(sfr_req_i),
        .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o), .acc_wr_i(acc_wr_i), .acc_wdata_i(acc_wdata_i),
        .b_wr_i(b_wr_i), .b_wdata_i(b_wdata_i), .flags_wr_i(flags_wr_i), .flags_i(flags_i),
        .stack_push_i(stack_push_i), .stack_pop_i(stack_pop_i), .data_pointer_load_i(data_pointer_load_i),
        .data_pointer_load_val_i(data_pointer_load_val_i), .data_pointer_inc_i(data_pointer_inc_i), .work_reg_i(work_reg_i),
        .data_ref_i(data_ref_i), .xmove_via_index_i(xmove_via_index_i), .xmove_index_i(xmove_index_i),
        .xram_disable_i(xram_disable_i), .code_addr_i(code_addr_i), .boot_blocks_i(boot_blocks_i),
        .code_lock_i(code_lock_i), .rc_osc_sel_i(rc_osc_sel_i), .acc_o(acc_o), .b_o(b_o), .flags_o(flags_o),
        .sp_o(sp_o), .data_pointer_o(data_pointer_o), .pointer_choice_o(pointer_choice_o), .work_reg_addr_o(work_reg_addr_o),
        .iram_sel_o(iram_sel_o), .sfr_sel_o(sfr_sel_o), .xmove_addr_o(xmove_addr_o), .xram_hit_o(xram_hit_o),
        .boot_area_o(boot_area_o), .boot_blocks_o(boot_blocks_o), .cycle_clocks_o(cycle_clocks_o),
        .cycle_strobe_o(cycle_strobe_o), .clock_pin_output_sel_o(clock_pin_output_sel_o),
        .boot_service_enable_o(boot_service_enable_o), .code_lock_status_o(code_lock_status_o),
        .sfr_page_mode_o(sfr_page_mode_o), .sfr_page_o(sfr_page_o), .ind_wr_o(ind_wr_o),
        .indirect_sfr_index_o(indirect_sfr_index_o), .indirect_sfr_value_o(indirect_sfr_value_o));

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // One write strobe, then a spare cycle so the register is visible
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        sfr_req_i = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        cyc(1);
        sfr_req_i.wr = 1'b0;
        cyc(1);
    endtask

    task automatic sfr_rd(input logic [7:0] a, input logic [7:0] e, input logic h);
        sfr_req_i = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        cyc(1);
        chk({7'h00, sfr_hit_o, sfr_rdata_o}, {7'h00, h, e});
        sfr_req_i.rd = 1'b0;
        cyc(1);
    endtask

    task automatic t_reset_stack();
        chk({sp_o, 4'h0, cycle_clocks_o}, 16'h0702);
        sfr_rd(`CMM_TIMING_ADDR, 8'h10, 1'b1);
        sfr_rd(8'h80, 8'h00, 1'b0);
        sfr_rd(`CMM_XPAGE_ADDR, 8'h00, 1'b1);
        stack_push_i = 1'b1;
        cyc(1);
        stack_push_i = 1'b0;
        cyc(1);
        chk({8'h00, sp_o}, 16'h0008);
        stack_pop_i = 1'b1;
        cyc(1);
        stack_pop_i = 1'b0;
        cyc(1);
        sfr_rd(`CMM_SP_ADDR, 8'h07, 1'b1);
    endtask

    task automatic t_timing();
        int n_strobe = 0;
        rc_osc_sel_i = 1'b1;
        for (int i = 0; i < 8; i++) begin
            sfr_wr(`CMM_TIMING_ADDR, {1'b0, i[2:0], 2'b00, i[1:0]});
            cyc(1);
            chk({cycle_clocks_o, 2'b00, clock_pin_output_sel_o}, {4'(i + 1), 4'(i % 4)});
        end
        rc_osc_sel_i = 1'b0;
        cyc(2);
        chk({14'h0000, clock_pin_output_sel_o}, 16'h0000);
        sfr_wr(`CMM_TIMING_ADDR, 8'hff);
        sfr_rd(`CMM_TIMING_ADDR, 8'h73, 1'b1);
        repeat (16) begin
            cyc(1);
            n_strobe += cycle_strobe_o;
        end
        chk(16'(n_strobe), 16'h0002);
    endtask

    task automatic t_iface_b();
        sfr_wr(`CMM_IFACE_ADDR, 8'hff);
        chk({15'h0000, boot_service_enable_o}, 16'h0001);
        code_lock_i = 1'b1;
        cyc(3);
        chk({15'h0000, code_lock_status_o}, 16'h0001);
        sfr_wr(`CMM_IFACE_ADDR, 8'h00);
        sfr_rd(`CMM_IFACE_ADDR, 8'h40, 1'b1);
        chk({15'h0000, boot_service_enable_o}, 16'h0000);
        code_lock_i = 1'b0;
        b_wr_i = 1'b1;
        b_wdata_i = 8'h5a;
        sfr_req_i = '{addr: `CMM_B_ADDR, wr: 1'b1, rd: 1'b0, wdata: 8'h33};
        cyc(1);
        b_wr_i = 1'b0;
        sfr_req_i.wr = 1'b0;
        cyc(1);
        chk({8'h00, b_o}, 16'h005a);
        sfr_wr(`CMM_B_ADDR, 8'hc3);
        sfr_rd(`CMM_B_ADDR, 8'hc3, 1'b1);
    endtask

    task automatic t_flags();
        logic [7:0] v [6] = '{8'h00, 8'h01, 8'h03, 8'h80, 8'hff, 8'h7e};
        foreach (v[k]) begin
            acc_wr_i = 1'b1;
            acc_wdata_i = v[k];
            cyc(1);
            acc_wr_i = 1'b0;
            cyc(1);
            chk({acc_o, 7'h00, flags_o[0]}, {v[k], 7'h00, ^v[k]});
        end
        flags_wr_i = 1'b1;
        flags_i = '{carry: 1'b1, half_carry: 1'b0, ovf: 1'b1};
        cyc(1);
        flags_wr_i = 1'b0;
        cyc(1);
        chk({12'h000, flags_o[7], flags_o[6], flags_o[2], flags_o[0]}, 16'h000a);
        work_reg_i = 3'h7;
        for (int r = 0; r < 4; r++) begin
            sfr_wr(`CMM_FLAGS_ADDR, {3'b000, r[1:0], 3'b000});
            cyc(1);
            chk({8'h00, work_reg_addr_o}, {11'h000, r[1:0], 3'b111});
        end
    endtask

    task automatic t_data_pointer();
        sfr_wr(`CMM_DP0L_ADDR, 8'h11);
        sfr_wr(`CMM_DP0H_ADDR, 8'h22);
        sfr_wr(`CMM_DP1L_ADDR, 8'h33);
        sfr_wr(`CMM_DP1H_ADDR, 8'h44);
        chk(data_pointer_o, 16'h2211);
        sfr_wr(`CMM_AUX_ADDR, 8'h01);
        chk({pointer_choice_o, data_pointer_o[14:0]}, 16'hc433);
        data_pointer_load_i = 1'b1;
        data_pointer_load_val_i = 16'h03fe;
        cyc(1);
        data_pointer_load_i = 1'b0;
        data_pointer_inc_i = 1'b1;
        cyc(1);
        data_pointer_inc_i = 1'b0;
        cyc(1);
        chk(data_pointer_o, 16'h03ff);
        sfr_rd(`CMM_DP0L_ADDR, 8'h11, 1'b1);
        sfr_rd(`CMM_DP1H_ADDR, 8'h03, 1'b1);
        chk({xmove_addr_o[14:0], xram_hit_o}, 16'h07ff);
    endtask

    task automatic t_maps();
        logic [8:0] refs [4] = '{9'h0fe, 9'h100, 9'h101, 9'h001};
        logic [1:0] sel [4] = '{2'b10, 2'b01, 2'b10, 2'b10};
        logic [15:0] ca [4] = '{16'h3f00, 16'h3eff, 16'h3fff, 16'h0000};
        sfr_wr(`CMM_XPAGE_ADDR, 8'h03);
        xmove_via_index_i = 1'b1;
        xmove_index_i = 8'hff;
        cyc(2);
        chk({xmove_addr_o[14:0], xram_hit_o}, 16'h07ff);
        xram_disable_i = 1'b1;
        cyc(2);
        chk({15'h0000, xram_hit_o}, 16'h0000);
        xram_disable_i = 1'b0;
        sfr_wr(`CMM_XPAGE_ADDR, 8'h04);
        chk({xmove_addr_o[14:0], xram_hit_o}, 16'h09fe);
        chk({12'h000, boot_blocks_o}, 16'h0002);
        foreach (refs[k]) begin
            data_ref_i = '{addr: refs[k][8:1], indirect: refs[k][0]};
            code_addr_i = ca[k];
            cyc(2);
            chk({14'h0000, iram_sel_o, sfr_sel_o}, {14'h0000, sel[k]});
            chk({15'h0000, boot_area_o}, {15'h0000, ca[k] >= 16'h3f00});
        end
    endtask

    task automatic t_indirect();
        logic seen;
        sfr_wr(`CMM_SFR_WINDOW_SELECT_ADDR, 8'h03);
        chk({14'h0000, sfr_page_mode_o, sfr_page_o}, 16'h0003);
        sfr_wr(`CMM_IND_VAL_ADDR, 8'h11);
        chk({8'h00, indirect_sfr_value_o}, 16'h0000);
        sfr_wr(`CMM_SFR_WINDOW_SELECT_ADDR, 8'h02);
        chk({14'h0000, sfr_page_mode_o, sfr_page_o}, 16'h0000);
        sfr_wr(`CMM_IND_IDX_ADDR, 8'hf5);
        sfr_req_i = '{addr: `CMM_IND_VAL_ADDR, wr: 1'b1, rd: 1'b0, wdata: 8'h80};
        seen = 1'b0;
        for (int i = 0; i < 3; i++) begin
            cyc(1);
            sfr_req_i.wr = 1'b0;
            if (ind_wr_o === 1'b1) begin
                seen = 1'b1;
                chk({indirect_sfr_index_o, indirect_sfr_value_o}, 16'hf580);
            end
        end
        chk({15'h0000, seen}, 16'h0001);
        if (seen !== 1'b1) begin
            final_report();
        end
    endtask

    task automatic final_report();
        $display("Checks %0d, errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        cyc(3);
        rstn_i = 1'b1;
        cyc(2);
        t_reset_stack();
        t_timing();
        t_iface_b();
        t_flags();
        t_data_pointer();
        t_maps();
        t_indirect();
        final_report();
    end
endmodule
`default_nettype wire
